// file: hw/pmio_top.sv
// Power monitor integration and output selection with an AHB-Lite register slave.
// Assumes the converter front end presents paired samples synchronous to hclk,
// the read/integrate pin is already synchronous, and the DAC and output buffer
// take dac_code, dac_load and dac_range.
`timescale 1ns/10ps
`include "pmio_defs.svh"

module pmio_top
    import pmio_pkg::*;
#(
    parameter int UPDATE_TIME_NS = `PMIO_UPDATE_TIME_NS,
    parameter int READ_TIME_NS = `PMIO_READ_TIME_NS,
    parameter int R2I_TIME_NS = `PMIO_R2I_TIME_NS
)(
    // Clock, reset, clock enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Host pin: high integrates, low reads
    input wire logic read_int,
    // Converter front end
    input wire logic smp_valid,
    input wire pmio_sample_s smp,
    output logic sense_en,
    output logic bus_en,
    // DAC and output buffer
    output logic [9:0] dac_code,
    output logic dac_load,
    output logic [1:0] dac_range,
    // Status
    output logic integrating
);
    function automatic logic [`PMIO_TCNT_W-1:0] cycles_min(input int ns);
        int c;
        c = (ns * `PMIO_CLK_MHZ + 999) / 1000;
        if (c < 1) begin
            c = 1;
        end
        return c[`PMIO_TCNT_W-1:0];
    endfunction

    function automatic logic [`PMIO_CNT_W-1:0] sample_target(input logic [3:0] code);
        // Codes past 2048 samples keep the 2048 cap
        if (code >= `PMIO_SMPL_MAX_CODE) begin
            return `PMIO_MAX_SAMPLES;
        end
        return `PMIO_CNT_W'(1) << code;
    endfunction

    function automatic logic is_pin_mode(input logic [1:0] sel);
        return sel == `PMIO_SEL_PIN_POWER;
    endfunction

    localparam logic [`PMIO_TCNT_W-1:0] UPDATE_CYC = cycles_min(UPDATE_TIME_NS);
    localparam logic [`PMIO_TCNT_W-1:0] READ_CYC = cycles_min(READ_TIME_NS);
    localparam logic [`PMIO_TCNT_W-1:0] R2I_CYC = cycles_min(R2I_TIME_NS);

    localparam pmio_top_s RESET_STATE = '{
        state: ST_READ,
        ctrl: `PMIO_CTRL_RESET,
        hreadyout: 1'b1,
        default: '0
    };

    pmio_top_s s_reg;
    pmio_top_s s_next;

    logic div_done;
    logic [`PMIO_ACC_W-1:0] div_quo;
    logic [`PMIO_ACC_W-1:0] average;
    logic [`PMIO_DATA_W-1:0] scaled;
    logic [2*`PMIO_DATA_W-1:0] product;
    logic [`PMIO_DATA_W-1:0] sample_value;
    logic addr_ok;
    logic [5:0] addr_idx;
    logic pin_read;
    logic go_integ;

    pmio_div u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .start(s_reg.div_start),
        .dividend(s_reg.acc),
        .divisor(s_reg.count),
        .done(div_done),
        .quotient(div_quo)
    );

    // No samples taken means a zero result rather than a divide by zero
    assign average = (s_reg.count == '0) ? '0 : div_quo;

    pmio_scale u_scale (
        .average(average),
        .sel(s_reg.active_sel),
        .current_digital_gain(s_reg.ctrl.current_digital_gain),
        .voltage_digital_gain(s_reg.ctrl.voltage_digital_gain),
        .result(scaled)
    );

    // Full scale of both inputs is 1023<<6, so the top half of the product
    // is the power code; the last part per thousand of range is not renormalised.
    assign product = smp.sense * smp.bus;

    always_comb begin
        unique case (s_reg.active_sel)
            `PMIO_SEL_SENSE: sample_value = smp.sense;
            `PMIO_SEL_BUS: sample_value = smp.bus;
            default: sample_value = product[2*`PMIO_DATA_W-1:`PMIO_DATA_W];
        endcase
    end

    assign addr_idx = haddr[7:2];
    assign addr_ok = hsel && htrans[1] && hready;
    assign pin_read = s_reg.low_cnt >= READ_CYC;
    assign go_integ = read_int && s_reg.low_seen;

    always_comb begin
        s_next = s_reg;
        s_next.dac_load = 1'b0;
        s_next.div_start = 1'b0;

        // Register bus; zero wait states, always OKAY
        s_next.hreadyout = 1'b1;
        s_next.hresp = 1'b0;
        if (s_reg.wr_pend && s_reg.wr_idx == `PMIO_IDX_CTRL) begin
            s_next.ctrl = hwdata;
            s_next.ctrl.rsv_hi = '0;
            s_next.ctrl.rsv_b = '0;
            s_next.ctrl.rsv_a = 1'b0;
        end
        s_next.wr_pend = addr_ok && hwrite;
        s_next.wr_idx = addr_idx;
        s_next.hrdata = '0;
        if (addr_ok && !hwrite) begin
            unique case (addr_idx)
                `PMIO_IDX_STATUS: s_next.hrdata = {26'h0, s_reg.result_valid,
                    s_reg.saturated, read_int, s_reg.state};
                `PMIO_IDX_COUNT: s_next.hrdata = {20'h0, s_reg.count};
                `PMIO_IDX_CTRL: s_next.hrdata = s_reg.ctrl;
                `PMIO_IDX_POWER: s_next.hrdata = {16'h0, s_reg.power_result};
                `PMIO_IDX_SENSE: s_next.hrdata = {16'h0, s_reg.sense_result};
                `PMIO_IDX_BUS: s_next.hrdata = {16'h0, s_reg.bus_result};
                `PMIO_IDX_DAC: s_next.hrdata = {22'h0, s_reg.dac_code};
                default: s_next.hrdata = '0;
            endcase
        end

        // Time the pin has been low, held at the read threshold
        if (read_int) begin
            s_next.low_cnt = '0;
        end else if (!pin_read) begin
            s_next.low_cnt = s_reg.low_cnt + `PMIO_TCNT_W'(1);
        end
        if (s_reg.low_cnt >= UPDATE_CYC) begin
            s_next.low_seen = 1'b1;
        end

        unique case (s_reg.state)
            ST_READ: begin
                if (read_int) begin
                    s_next.state = ST_R2I;
                    s_next.r2i_cnt = '0;
                end
            end
            ST_R2I: begin
                s_next.r2i_cnt = s_reg.r2i_cnt + `PMIO_TCNT_W'(1);
                if (pin_read) begin
                    s_next.state = ST_READ;
                end else if (s_reg.r2i_cnt + `PMIO_TCNT_W'(1) >= R2I_CYC) begin
                    s_next.state = ST_INTEG;
                end
            end
            ST_INTEG: begin
                // Samples count only while the pin is high
                if (smp_valid && read_int && s_reg.count < s_reg.target) begin
                    s_next.acc = s_reg.acc + `PMIO_ACC_W'(sample_value);
                    s_next.count = s_reg.count + `PMIO_CNT_W'(1);
                end
                if (is_pin_mode(s_reg.active_sel)) begin
                    if (s_reg.low_cnt >= UPDATE_CYC) begin
                        s_next.state = ST_DIVIDE;
                        s_next.div_start = 1'b1;
                        s_next.acc = s_reg.acc;
                        s_next.count = s_reg.count;
                    end else if (s_reg.count == `PMIO_MAX_SAMPLES) begin
                        s_next.state = ST_DIVIDE;
                        s_next.div_start = 1'b1;
                        s_next.saturated = 1'b1;
                    end
                end else if (pin_read) begin
                    // Read state abandons a partial free-run period
                    s_next.state = ST_READ;
                end else if (s_reg.count == s_reg.target) begin
                    s_next.state = ST_DIVIDE;
                    s_next.div_start = 1'b1;
                end
            end
            ST_DIVIDE: begin
                if (div_done) begin
                    s_next.state = ST_SCALE;
                end
            end
            ST_SCALE: begin
                unique case (s_reg.active_sel)
                    `PMIO_SEL_SENSE: s_next.sense_result = scaled;
                    `PMIO_SEL_BUS: s_next.bus_result = scaled;
                    default: s_next.power_result = scaled;
                endcase
                s_next.dac_code = scaled[`PMIO_DATA_W-1:`PMIO_DAC_LSB];
                s_next.dac_load = 1'b1;
                s_next.result_valid = 1'b1;
                if (pin_read) begin
                    s_next.state = ST_READ;
                end else if (!is_pin_mode(s_reg.active_sel) || go_integ) begin
                    s_next.state = ST_INTEG;
                end else begin
                    s_next.state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (pin_read) begin
                    s_next.state = ST_READ;
                end else if (go_integ) begin
                    s_next.state = ST_INTEG;
                end
            end
            default: s_next.state = ST_READ;
        endcase

        // A new period latches the selector so a mid-period write waits
        if (s_next.state == ST_INTEG && s_reg.state != ST_INTEG) begin
            s_next.active_sel = s_reg.ctrl.output_type_select;
            s_next.target = is_pin_mode(s_reg.ctrl.output_type_select) ?
                `PMIO_MAX_SAMPLES : sample_target(s_reg.ctrl.sample_code);
            s_next.acc = '0;
            s_next.count = '0;
            s_next.saturated = 1'b0;
            s_next.low_seen = 1'b0;
        end

        // Only the channels the type needs are converted
        s_next.integrating = s_next.state == ST_INTEG;
        s_next.sense_en = s_next.integrating && s_next.active_sel != `PMIO_SEL_BUS;
        s_next.bus_en = s_next.integrating && s_next.active_sel != `PMIO_SEL_SENSE;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= RESET_STATE;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign hreadyout = s_reg.hreadyout;
    assign hresp = s_reg.hresp;
    assign hrdata = s_reg.hrdata;
    assign sense_en = s_reg.sense_en;
    assign bus_en = s_reg.bus_en;
    assign dac_code = s_reg.dac_code;
    assign dac_load = s_reg.dac_load;
    assign dac_range = s_reg.ctrl.output_range_select;
    assign integrating = s_reg.integrating;

endmodule // pmio_top

// file: hw/pmio_defs.svh
// Constants of the power monitor integration and output logic.
// Included by the package and by every design file; holds definitions only.
`ifndef PMIO_DEFS_SVH
`define PMIO_DEFS_SVH

// Clock rate and timing figures (times in ns)
`define PMIO_CLK_MHZ 40
`define PMIO_UPDATE_TIME_NS 100000
`define PMIO_READ_TIME_NS 1000000
`define PMIO_R2I_TIME_NS 50000
`define PMIO_TCNT_W 24

// Sample counting
`define PMIO_CNT_W 12
`define PMIO_MAX_SAMPLES 12'h800
`define PMIO_SMPL_MAX_CODE 4'hb

// Data path
`define PMIO_DATA_W 16
`define PMIO_ACC_W 28
`define PMIO_FULL_SCALE 16'hffc0
`define PMIO_DAC_LSB 6
`define PMIO_IGAIN_MAX 3'h6

// Measurement selector codes
`define PMIO_SEL_PIN_POWER 2'h0
`define PMIO_SEL_SENSE 2'h1
`define PMIO_SEL_BUS 2'h2
`define PMIO_SEL_FREE_POWER 2'h3

// Register indices; byte address is four times the index
`define PMIO_IDX_STATUS 6'h00
`define PMIO_IDX_COUNT 6'h01
`define PMIO_IDX_CTRL 6'h02
`define PMIO_IDX_POWER 6'h03
`define PMIO_IDX_SENSE 6'h04
`define PMIO_IDX_BUS 6'h05
`define PMIO_IDX_DAC 6'h06
`define PMIO_CTRL_RESET 32'h0000_0000

`endif

// file: hw/pmio_pkg.sv
// Types shared by the power monitor integration and output logic.
// Assumes pmio_defs.svh is on the include path.
`include "pmio_defs.svh"

package pmio_pkg;

    typedef enum logic [2:0] {
        ST_READ,
        ST_R2I,
        ST_INTEG,
        ST_DIVIDE,
        ST_SCALE,
        ST_HOLD
    } pmio_state_e;

    // Control register layout
    typedef struct packed {
        logic [15:0] rsv_hi;
        logic [3:0] sample_code;
        logic [1:0] rsv_b;
        logic [1:0] voltage_digital_gain;
        logic rsv_a;
        logic [2:0] current_digital_gain;
        logic [1:0] output_range_select;
        logic [1:0] output_type_select;
    } pmio_ctrl_s;

    // One digitized pair from the converter front end
    typedef struct packed {
        logic [`PMIO_DATA_W-1:0] sense;
        logic [`PMIO_DATA_W-1:0] bus;
    } pmio_sample_s;

    typedef struct packed {
        logic busy;
        logic done;
        logic [4:0] cnt;
        logic [`PMIO_CNT_W-1:0] divisor;
        logic [`PMIO_CNT_W-1:0] rem;
        logic [`PMIO_ACC_W-1:0] quo;
    } pmio_div_s;

    typedef struct packed {
        pmio_state_e state;
        pmio_ctrl_s ctrl;
        logic [1:0] active_sel;
        logic [`PMIO_ACC_W-1:0] acc;
        logic [`PMIO_CNT_W-1:0] count;
        logic [`PMIO_CNT_W-1:0] target;
        logic [`PMIO_TCNT_W-1:0] low_cnt;
        logic [`PMIO_TCNT_W-1:0] r2i_cnt;
        logic low_seen;
        logic saturated;
        logic result_valid;
        logic [`PMIO_DATA_W-1:0] power_result;
        logic [`PMIO_DATA_W-1:0] sense_result;
        logic [`PMIO_DATA_W-1:0] bus_result;
        logic [9:0] dac_code;
        logic dac_load;
        logic div_start;
        logic sense_en;
        logic bus_en;
        logic integrating;
        logic wr_pend;
        logic [5:0] wr_idx;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } pmio_top_s;

endpackage

// file: hw/pmio_div.sv
// Iterative restoring divider: accumulated sum over sample count.
// Assumes start is a one-cycle pulse with operands stable on that cycle.
`timescale 1ns/10ps
`include "pmio_defs.svh"

module pmio_div
    import pmio_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Request
    input wire logic start,
    input wire logic [`PMIO_ACC_W-1:0] dividend,
    input wire logic [`PMIO_CNT_W-1:0] divisor,
    // Answer
    output logic done,
    output logic [`PMIO_ACC_W-1:0] quotient
);
    localparam logic [4:0] LAST = 5'(`PMIO_ACC_W - 1);

    pmio_div_s s_reg;
    pmio_div_s s_next;
    logic [`PMIO_CNT_W:0] trial;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        trial = {s_reg.rem, s_reg.quo[`PMIO_ACC_W-1]};
        if (start) begin
            s_next.busy = 1'b1;
            s_next.cnt = 5'h00;
            s_next.rem = '0;
            s_next.quo = dividend;
            s_next.divisor = divisor;
        end else if (s_reg.busy) begin
            // One quotient bit per cycle keeps the adder narrow
            if (trial >= {1'b0, s_reg.divisor}) begin
                s_next.rem = trial[`PMIO_CNT_W-1:0] - s_reg.divisor;
                s_next.quo = {s_reg.quo[`PMIO_ACC_W-2:0], 1'b1};
            end else begin
                s_next.rem = trial[`PMIO_CNT_W-1:0];
                s_next.quo = {s_reg.quo[`PMIO_ACC_W-2:0], 1'b0};
            end
            s_next.cnt = s_reg.cnt + 5'h01;
            if (s_reg.cnt == LAST) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign done = s_reg.done;
    assign quotient = s_reg.quo;

endmodule // pmio_div

// file: hw/pmio_scale.sv
// Digital gain and clamp of an averaged measurement.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`include "pmio_defs.svh"

module pmio_scale
    import pmio_pkg::*;
(
    // Operand
    input wire logic [`PMIO_ACC_W-1:0] average,
    input wire logic [1:0] sel,
    // Gains
    input wire logic [2:0] current_digital_gain,
    input wire logic [1:0] voltage_digital_gain,
    // Result
    output logic [`PMIO_DATA_W-1:0] result
);
    logic [2:0] ishift;
    logic [3:0] shift;
    logic [`PMIO_ACC_W+15:0] wide;

    always_comb begin
        // Codes above the top gain are held at the top gain
        ishift = (current_digital_gain > `PMIO_IGAIN_MAX) ? `PMIO_IGAIN_MAX :
                 current_digital_gain;
        unique case (sel)
            `PMIO_SEL_SENSE: shift = {1'b0, ishift};
            `PMIO_SEL_BUS: shift = {2'b00, voltage_digital_gain};
            default: shift = {1'b0, ishift} + {2'b00, voltage_digital_gain};
        endcase
        wide = {16'h0000, average} << shift;
        // Over-range saturates at full scale instead of wrapping
        if (wide > {{(`PMIO_ACC_W){1'b0}}, `PMIO_FULL_SCALE}) begin
            result = `PMIO_FULL_SCALE;
        end else begin
            result = wide[`PMIO_DATA_W-1:0];
        end
    end

endmodule // pmio_scale

// file: bench/pmio_checker.sv
// Port assertions for the power monitor integration and output top.
// Assumes one clock, hclk, and hresetn asynchronous and active low.
`timescale 1ns/10ps
`include "pmio_defs.svh"

module pmio_checker #(
    parameter int UPDATE_TIME_NS = 200,
    parameter int READ_TIME_NS = 1000
)(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Measurement and output
    input wire logic read_int,
    input wire logic sense_en,
    input wire logic bus_en,
    input wire logic [9:0] dac_code,
    input wire logic dac_load,
    input wire logic [1:0] dac_range,
    input wire logic integrating
);
    localparam int UPD_CYC = (UPDATE_TIME_NS * `PMIO_CLK_MHZ + 999) / 1000;
    localparam int READ_CYC = (READ_TIME_NS * `PMIO_CLK_MHZ + 999) / 1000;
    logic take;
    logic wr_ctrl_q, wr_done, rd_unm_q, rd_dac_q;
    logic [1:0] wd_q;
    logic [7:0] low_cnt;
    assign take = hsel && htrans[1] && hready;
    // An address phase arms a check for the data phase that follows it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ctrl_q <= 1'b0;
            wr_done <= 1'b0;
            rd_unm_q <= 1'b0;
            rd_dac_q <= 1'b0;
            wd_q <= 2'h0;
            low_cnt <= 8'h00;
        end else begin
            wr_ctrl_q <= take && hwrite && haddr == 32'h0000_0008;
            wr_done <= wr_ctrl_q;
            wd_q <= hwdata[3:2];
            rd_unm_q <= take && !hwrite && haddr[31:2] > 30'h6;
            rd_dac_q <= take && !hwrite && haddr == 32'h0000_0018;
            low_cnt <= read_int ? 8'h00 : low_cnt + {7'h0, low_cnt != 8'hff};
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait OKAY");
    a_load_pulse: assert property (dac_load |=> !dac_load)
        else $error("dac_load longer than one cycle");
    a_code_on_load: assert property ($changed(dac_code) |-> dac_load)
        else $error("dac_code changed without dac_load");
    a_load_after_end: assert property ($fell(integrating) && read_int |-> ##[1:40] dac_load)
        else $error("period ended without an output update");
    a_read_stops: assert property (low_cnt == 8'(READ_CYC + 2) |-> !integrating)
        else $error("integration goes on after a long low pin");
    a_int_needs_pin: assert property ($rose(integrating) |-> $past(read_int))
        else $error("integration began with the pin low");
    a_en_integ: assert property ((sense_en || bus_en) |-> integrating || $past(integrating))
        else $error("converter enabled outside integration");
    a_range_write: assert property (wr_done |-> ##[0:1] dac_range == wd_q)
        else $error("dac_range does not follow the written range field");
    a_unmapped_zero: assert property (rd_unm_q |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_dac_read: assert property (rd_dac_q |-> hrdata == {22'h0, dac_code})
        else $error("DAC register read differs from dac_code");
    cover property (dac_load && read_int);
    cover property (low_cnt == 8'(UPD_CYC) && integrating);
    cover property (wr_done);
endmodule // pmio_checker

// file: bench/pmio_host.sv
// Host model: drives the read/integrate pin and samples the output code.
// Assumes the bench commands the pin level through hold_low.
`timescale 1ns/10ps

module pmio_host #(
    // Settle wait in clock cycles; the value is arbitrary
    parameter int OUTPUT_SETTLE_TIME = 6
)(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench command
    input wire logic hold_low,
    // Device side
    input wire logic dac_load,
    input wire logic [9:0] dac_code,
    output logic read_int,
    output logic [9:0] settled_code
);
    logic [3:0] wait_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            read_int <= 1'b0;
            wait_cnt <= 4'h0;
            settled_code <= 10'h000;
        end else begin
            // Low only as long as asked: a short low updates without the read delay
            read_int <= !hold_low;
            if (dac_load) begin
                wait_cnt <= 4'(OUTPUT_SETTLE_TIME);
            end else if (wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
            // The output is not trusted before it has settled
            if (wait_cnt == 4'h1) begin
                settled_code <= dac_code;
            end
        end
    end
endmodule // pmio_host

// file: bench/testbench.sv
// Self-checking bench for the power monitor integration top.
// Assumes pmio_defs.svh on the include path; short times keep the run small.
`timescale 1ns/10ps
`include "pmio_defs.svh"
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end

module testbench
    import pmio_pkg::*;
();
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] s0, b0, st;
        logic [11:0] n;
        logic [7:0] addr;
        logic [15:0] res;
    } pmio_row_s;
    pmio_row_s rows [7] = '{
        '{32'h1, 16'h8000, 16'h0, 16'h0, 12'h1, 8'h10, 16'h8000},
        '{32'h25, 16'h1000, 16'h0, 16'h0, 12'h1, 8'h10, 16'h4000},
        '{32'h61, 16'h0400, 16'h0, 16'h0, 12'h1, 8'h10, 16'hffc0},
        '{32'h10a, 16'h0, 16'h2000, 16'h0, 12'h1, 8'h14, 16'h4000},
        '{32'hf, 16'h8000, 16'h8000, 16'h0, 12'h1, 8'h0c, 16'h4000},
        '{32'h1f, 16'h8000, 16'h8000, 16'h0, 12'h1, 8'h0c, 16'h8000},
        '{32'h2001, 16'h1000, 16'h0, 16'h1000, 12'h5, 8'h10, 16'h2800}};
    int bad_count = 0;
    int checks = 0;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, smp_valid = 1'b0, hold_low = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    pmio_sample_s smp = '0;
    logic hreadyout, hresp, read_int, sense_en, bus_en, dac_load, integrating;
    logic [31:0] hrdata;
    logic [9:0] dac_code, settled_code;
    logic [1:0] dac_range;

    always #12.5 hclk = ~hclk;

    pmio_top #(.UPDATE_TIME_NS(200), .READ_TIME_NS(1000), .R2I_TIME_NS(100)) u_pmio_top (
        .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .read_int(read_int), .smp_valid(smp_valid), .smp(smp), .sense_en(sense_en),
        .bus_en(bus_en), .dac_code(dac_code), .dac_load(dac_load), .dac_range(dac_range),
        .integrating(integrating));
    pmio_host u_pmio_host (.hclk(hclk), .hresetn(hresetn), .hold_low(hold_low),
        .dac_load(dac_load), .dac_code(dac_code), .read_int(read_int),
        .settled_code(settled_code));

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic push(input logic [15:0] s0, b0, st, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            smp_valid <= 1'b1;
            smp <= {s0 + 16'(i) * st, b0 + 16'(i) * st};
        end
        @(posedge hclk);
        smp_valid <= 1'b0;
    endtask

    // which low waits for integration, high for an output update
    task automatic wait_on(input logic which, input int lim);
        int k;
        k = 0;
        do begin @(posedge hclk); k++; end
        while ((which ? dac_load : integrating) !== 1'b1 && k < lim);
        `CHK("wait", 1'b1, which ? dac_load : integrating)
    endtask

    task automatic results();
        $display("Checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        `CHK("dac_code", 10'h0, dac_code)
        `CHK("dac_range", 2'h0, dac_range)
        bus(1'b0, 32'h8, 32'h0);
        `CHK("ctrl", 32'h0, rd)
        // Pin-controlled power, then a low just past the update time
        hold_low <= 1'b0;
        wait_on(1'b0, 200);
        push(16'h4000, 16'h4000, 16'h4000, 2);
        hold_low <= 1'b1;
        repeat (10) @(posedge hclk);
        hold_low <= 1'b0;
        wait_on(1'b1, 60);
        `CHK("pin power", 10'h0a0, dac_code)
        repeat (3) @(posedge hclk);
        `CHK("no read delay", 1'b1, integrating)
        repeat (8) @(posedge hclk);
        `CHK("settled", 10'h0a0, settled_code)
        push(16'h8000, 16'h8000, 16'h0, 2048);
        wait_on(1'b1, 60);
        `CHK("saturated", 10'h100, dac_code)
        bus(1'b0, 32'h0, 32'h0);
        `CHK("status sat", 2'h3, rd[5:4])
        foreach (rows[i]) begin
            hold_low <= 1'b1;
            repeat (50) @(posedge hclk);
            bus(1'b1, 32'h8, rows[i].ctrl);
            hold_low <= 1'b0;
            wait_on(1'b0, 100);
            push(rows[i].s0, rows[i].b0, rows[i].st, rows[i].n);
            wait_on(1'b1, 60);
            `CHK("dac_code", rows[i].res[15:6], dac_code)
            `CHK("dac_range", rows[i].ctrl[3:2], dac_range)
            bus(1'b0, {24'h0, rows[i].addr}, 32'h0);
            `CHK("result", {16'h0, rows[i].res}, rd)
        end
        bus(1'b1, 32'h8, 32'hffff_ffff);
        bus(1'b0, 32'h8, 32'h0);
        `CHK("ctrl mask", 32'h0000_f37f, rd)
        bus(1'b1, 32'h18, 32'hffff_ffff);
        bus(1'b0, 32'h18, 32'h0);
        `CHK("dac reg", 32'h0000_00a0, rd)
        bus(1'b0, 32'h40, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        // Reset in mid-run must bring output and control back to defaults
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        `CHK("reset dac", 10'h0, dac_code)
        `CHK("reset integ", 1'b0, integrating)
        bus(1'b0, 32'h8, 32'h0);
        `CHK("reset ctrl", 32'h0, rd)
        results();
    end

    initial begin
        repeat (10000) @(posedge hclk);
        bad_count++;
        results();
    end
endmodule // testbench

bind pmio_top pmio_checker #(.UPDATE_TIME_NS(UPDATE_TIME_NS), .READ_TIME_NS(READ_TIME_NS))
    u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .read_int(read_int), .sense_en(sense_en),
    .bus_en(bus_en), .dac_code(dac_code), .dac_load(dac_load), .dac_range(dac_range),
    .integrating(integrating));
